// [bench/cer_top_bench.sv]
// self-checking bench for the cpu error reporting top
`timescale 1ns/1ps
module cer_top_bench;
   logic sys_clk = 1'b0, reset_n = 1'b0, bcc_wr = 1'b0, diag_wr = 1'b0, diag_wdata = 1'b0, stat_wr = 1'b0;
   logic [1:0] bcc_wdata = 2'h0, backup_cache_control;
   logic [3:0] stat_wdata = 4'h0, bus_interface_error_status;
   logic [31:0] error_address, rd_addr = 32'h0, err_evt_addr = 32'h0, note_target;
   logic [7:0] fill_syndrome, line_index = 8'h0, rd_syndrome = 8'h0, note_vector;
   logic [63:0] line_data = 64'h0, mem_data = 64'h0, rd_data, cache_wr_data = 64'h0;
   logic rd_valid = 1'b0, rd_ecc_err = 1'b0, rd_uncorrectable = 1'b0, rd_done, rd_hit;
   logic soft_err_evt = 1'b0, hard_err_evt = 1'b0, sync_err_evt = 1'b0, mm_fault = 1'b0, pushing_stack = 1'b0;
   logic halt_evt = 1'b0, insn_boundary = 1'b0, return_from_exception = 1'b0;
   logic bad_parity_pc = 1'b0, bad_parity_ic = 1'b0, pc_parity, ic_parity;
   logic note_valid, abort_insn, retry_pending;
   logic [2:0] note_kind;
   logic [4:0] interrupt_priority_level = 5'h00;
   int err_count = 0;
   int checks = 0;
   cer_top u_cer_top (.sys_clk, .reset_n, .bcc_wr, .bcc_wdata, .backup_cache_control, .diag_wr, .diag_wdata,
      .stat_wr, .stat_wdata, .bus_interface_error_status, .error_address, .fill_syndrome, .rd_valid, .rd_addr,
      .line_index, .line_data, .mem_data, .rd_syndrome, .rd_ecc_err, .rd_uncorrectable, .rd_done, .rd_data,
      .rd_hit, .soft_err_evt, .hard_err_evt, .err_evt_addr, .sync_err_evt, .mm_fault, .pushing_stack, .halt_evt,
      .insn_boundary, .return_from_exception, .interrupt_priority_level, .cache_wr_data, .bad_parity_pc,
      .bad_parity_ic, .pc_parity, .ic_parity, .note_valid, .note_kind, .note_vector, .note_target, .abort_insn,
      .retry_pending);
   // 8 ns clock
   always begin
      #4 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // inputs move 1 ns after the edge so sampling never races
   task automatic step(input int n = 1);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // bounded wait for a notification
   task automatic wait_note();
      int i;
      i = 0;
      while (note_valid !== 1'b1 && i < 6) begin
         step();
         i++;
      end
      chk(note_valid, 1'b1);
   endtask
   task automatic retire();
      return_from_exception = 1'b1;
      step();
      return_from_exception = 1'b0;
      step(2);
   endtask
   task automatic t_reset();
      chk({backup_cache_control, bus_interface_error_status, note_valid, rd_done, abort_insn}, 64'h0);
      $display("test reset done");
   endtask
   task automatic t_force_hit();
      bcc_wr = 1'b1;
      bcc_wdata = 2'h2;
      step();
      bcc_wr = 1'b0;
      chk(backup_cache_control, 2'h2);
      {rd_valid, rd_addr, line_index} = {1'b1, 32'h0000_1234, 8'h34};
      {line_data, mem_data} = {64'hA5A5_0F0F_1234_5678, 64'h0};
      step();
      rd_valid = 1'b0;
      chk({rd_done, rd_hit}, 2'h3);
      chk(rd_data, 64'hA5A5_0F0F_1234_5678);
      rd_valid = 1'b1;
      rd_ecc_err = 1'b1;
      step();
      rd_addr = 32'h0000_5634;
      step();
      {rd_valid, rd_ecc_err} = 2'h0;
      chk(bus_interface_error_status[2], 1'b1);
      chk(bus_interface_error_status[3], 1'b1);
      chk(error_address, 32'h0000_1234);
      step(4);
      chk({bus_interface_error_status[3], bus_interface_error_status[2]}, 2'h3);
      {stat_wr, stat_wdata} = {1'b1, 4'hF};
      step();
      stat_wr = 1'b0;
      step();
      chk(bus_interface_error_status, 4'h0);
      $display("test force_hit done");
   endtask
   task automatic t_syndrome();
      {diag_wr, diag_wdata} = 2'h3;
      step();
      diag_wr = 1'b0;
      for (int s = 0; s < 2; s++) begin
         {rd_valid, rd_syndrome} = {1'b1, 8'h5A ^ 8'(s)};
         step();
         rd_valid = 1'b0;
         chk(fill_syndrome, 8'h5A ^ 8'(s));
      end
      {diag_wr, diag_wdata, bcc_wr, bcc_wdata} = {2'h2, 1'b1, 2'h0};
      step();
      {diag_wr, bcc_wr} = 2'h0;
      chk(backup_cache_control, 2'h0);
      {bcc_wr, bcc_wdata} = 3'h5;
      step();
      bcc_wr = 1'b0;
      chk(backup_cache_control, 2'h1);
      $display("test syndrome done");
   endtask
   task automatic t_irq(input int bit_no, input logic [2:0] kind, input logic [7:0] vec);
      {hard_err_evt, soft_err_evt} = (bit_no == 0) ? 2'h2 : 2'h1;
      step();
      {hard_err_evt, soft_err_evt} = 2'h0;
      step(3);
      chk(note_valid, 1'b0);
      insn_boundary = 1'b1;
      wait_note();
      chk({note_kind, note_vector}, {kind, vec});
      {stat_wr, stat_wdata} = {1'b1, 4'h1 << bit_no};
      step();
      stat_wr = 1'b0;
      step(2);
      chk(note_valid, 1'b0);
      insn_boundary = 1'b0;
      $display("test irq done");
   endtask
   task automatic t_mchk();
      hard_err_evt = 1'b1;
      step();
      {hard_err_evt, sync_err_evt} = 2'h1;
      step();
      sync_err_evt = 1'b0;
      // hard interrupt becomes takeable while machine check is pending
      insn_boundary = 1'b1;
      wait_note();
      chk({note_kind, note_vector, abort_insn}, {3'h3, 8'h04, 1'b1});
      {insn_boundary, return_from_exception} = 2'h3;
      begin : retry_wait
         int i;
         for (i = 0; i < 4 && retry_pending !== 1'b1; i++) step();
         chk(retry_pending, 1'b1);
      end
      {insn_boundary, return_from_exception, stat_wr, stat_wdata} = {3'h1, 4'hF};
      step();
      stat_wr = 1'b0;
      step(2);
      $display("test mchk done");
   endtask
   task automatic t_halt_ksnv();
      {halt_evt, sync_err_evt} = 2'h3;
      step();
      sync_err_evt = 1'b0;
      wait_note();
      chk({note_kind, note_target}, {3'h1, 32'h2000_0000});
      halt_evt = 1'b0;
      retire();
      retire();
      {mm_fault, pushing_stack} = 2'h3;
      step();
      {mm_fault, pushing_stack} = 2'h0;
      wait_note();
      chk({note_kind, note_vector}, {3'h2, 8'h08});
      retire();
      $display("test halt_ksnv done");
   endtask
   task automatic t_parity();
      for (int b = 0; b < 4; b++) begin
         {cache_wr_data, bad_parity_pc, bad_parity_ic} = {64'h7 << b, b[0], b[1]};
         step();
         // three set data bits give odd parity before injection
         chk({pc_parity, ic_parity}, {~b[0], ~b[1]});
      end
      $display("test parity done");
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // watchdog well beyond the expected run of under a hundred cycles
   initial begin
      #(8 * 3000);
      err_count++;
      tally_and_finish();
   end
   initial begin
      step(12);
      reset_n = 1'b1;
      t_reset();
      t_force_hit();
      t_syndrome();
      t_irq(0, 3'h6, 8'h60);
      t_irq(1, 3'h7, 8'h54);
      t_mchk();
      t_halt_ksnv();
      t_parity();
      tally_and_finish();
   end
endmodule

// [bench/cer_top_properties.sv]
// concurrent checks on the cpu error reporting top ports
`timescale 1ns/1ps
module cer_top_checker (
   input wire logic        sys_clk,
   input wire logic        reset_n,
   input wire logic        bcc_wr,
   input wire logic [1:0]  bcc_wdata,
   input wire logic [1:0]  backup_cache_control,
   input wire logic        diag_wr,
   input wire logic        diag_wdata,
   input wire logic        stat_wr,
   input wire logic [3:0]  stat_wdata,
   input wire logic [3:0]  bus_interface_error_status,
   input wire logic [7:0]  fill_syndrome,
   input wire logic        rd_valid,
   input wire logic [31:0] rd_addr,
   input wire logic [7:0]  line_index,
   input wire logic [63:0] line_data,
   input wire logic [7:0]  rd_syndrome,
   input wire logic        rd_ecc_err,
   input wire logic        rd_uncorrectable,
   input wire logic        rd_hit,
   input wire logic [63:0] rd_data,
   input wire logic        soft_err_evt,
   input wire logic        hard_err_evt,
   input wire logic        insn_boundary,
   input wire logic        return_from_exception,
   input wire logic [63:0] cache_wr_data,
   input wire logic        bad_parity_pc,
   input wire logic        pc_parity,
   input wire logic        note_valid,
   input wire logic [2:0]  note_kind,
   input wire logic [7:0]  note_vector,
   input wire logic [31:0] note_target,
   input wire logic        abort_insn,
   input wire logic        retry_pending
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   logic diag_on;
   logic next_diag_on;
   // shadow of the disable-errors mode, since it has no output port
   always_comb begin
      next_diag_on = diag_on;
      if (diag_wr) begin
         next_diag_on = diag_wdata;
      end
   end
   always_ff @(posedge sys_clk) begin
      diag_on <= reset_n ? next_diag_on : 1'b0;
   end
   chk_force_hit_data: assert property (rd_valid && backup_cache_control[1] && rd_addr[7:0] == line_index
      && !rd_uncorrectable |=> rd_hit && rd_data == $past(line_data)) else $error("force hit read missed");
   chk_fill_ecc_flag: assert property (rd_valid && rd_ecc_err && !rd_uncorrectable
      && bus_interface_error_status == 4'h0 |=> bus_interface_error_status[2]) else $error("fill ecc not flagged");
   chk_syndrome_every_read: assert property (diag_on && rd_valid |=> fill_syndrome == $past(rd_syndrome))
      else $error("syndrome not captured");
   chk_control_write: assert property (bcc_wr |=> backup_cache_control == $past(bcc_wdata))
      else $error("control write lost");
   chk_mchk_vector: assert property (note_valid && note_kind == 3'h3 |-> note_vector == 8'h04 && abort_insn)
      else $error("machine check vector wrong");
   chk_halt_target: assert property (note_valid && note_kind == 3'h1 |-> note_target == 32'h2000_0000)
      else $error("halt target wrong");
   chk_irq_boundary: assert property (note_valid && note_kind[2:1] == 2'h3 |-> $past(insn_boundary))
      else $error("error interrupt off boundary");
   chk_retry_cause: assert property (retry_pending |-> $past(return_from_exception))
      else $error("retry without return");
   chk_parity_inject: assert property (pc_parity == (^cache_wr_data ^ bad_parity_pc))
      else $error("parity injection wrong");
   chk_soft_vector: assert property (note_valid && note_kind == 3'h7 |-> note_vector == 8'h54)
      else $error("soft vector wrong");
   chk_hard_vector: assert property (note_valid && note_kind == 3'h6 |-> note_vector == 8'h60)
      else $error("hard vector wrong");
   chk_w1c_clear: assert property (stat_wr && !hard_err_evt && !soft_err_evt && !rd_valid
      |=> (bus_interface_error_status & $past(stat_wdata)) == 4'h0) else $error("status bit not cleared");
   chk_second_error_keep: assert property ((soft_err_evt || hard_err_evt || rd_valid && rd_ecc_err)
      && bus_interface_error_status[2:0] != 3'h0 && !stat_wr |=> bus_interface_error_status[3]
      && bus_interface_error_status[2:0] == $past(bus_interface_error_status[2:0]))
      else $error("second error disturbed status");
   chk_status_sticky: assert property (!stat_wr |=> ($past(bus_interface_error_status)
      & ~bus_interface_error_status) == 4'h0) else $error("status bit dropped");
   cov_hit: cover property (rd_hit);
   cov_hard: cover property (note_valid && note_kind == 3'h6);
   cov_mchk: cover property (note_valid && note_kind == 3'h3);
   cov_halt: cover property (note_valid && note_kind == 3'h1);
endmodule
bind cer_top cer_top_checker u_chk (.sys_clk, .reset_n, .bcc_wr, .bcc_wdata, .backup_cache_control, .diag_wr,
   .diag_wdata, .stat_wr, .stat_wdata, .bus_interface_error_status, .fill_syndrome, .rd_valid, .rd_addr,
   .line_index, .line_data, .rd_syndrome, .rd_ecc_err, .rd_uncorrectable, .rd_hit, .rd_data, .soft_err_evt,
   .hard_err_evt, .insn_boundary, .return_from_exception, .cache_wr_data, .bad_parity_pc, .pc_parity,
   .note_valid, .note_kind, .note_vector, .note_target, .abort_insn, .retry_pending);

// [common/cer_pkg.sv]
// package of constants and types for the cpu error reporting block
package cer_pkg;
   // vector table indices
   localparam logic [7:0] VEC_MACHINE_CHECK = 8'h04;
   localparam logic [7:0] VEC_KSNV          = 8'h08;
   localparam logic [7:0] VEC_SOFT_ERROR    = 8'h54;
   localparam logic [7:0] VEC_HARD_ERROR    = 8'h60;
   // console halt entry, fixed i/o-space address (arbitrary plain default)
   localparam logic [31:0] CONSOLE_HALT_ADDR = 32'h2000_0000;
   // backup_cache_control field positions
   localparam int BCC_ENABLE_BIT    = 0;
   localparam int BCC_FORCE_HIT_BIT = 1;
   localparam logic [1:0] BCC_RESET = 2'h0;
   // diagnostic_control field positions
   localparam int DIAG_DISABLE_ERRORS_BIT = 0;
   // bus_interface_error_status field positions
   localparam int ST_HARD_BIT     = 0;
   localparam int ST_SOFT_BIT     = 1;
   localparam int ST_FILL_ECC_BIT = 2;
   localparam int ST_SEO_BIT      = 3;
   localparam int ST_WIDTH        = 4;
   localparam logic [3:0] ST_RESET = 4'h0;
   // widths
   localparam int ADDR_W  = 32;
   localparam int INDEX_W = 8;
   localparam int DATA_W  = 64;
   localparam int SYND_W  = 8;
   localparam int IPL_W   = 5;
   // interrupt priority levels of the two error interrupts
   localparam logic [4:0] IPL_SOFT = 5'h1A;
   localparam logic [4:0] IPL_HARD = 5'h1D;
   // notification kinds, in descending severity
   typedef enum logic [2:0] {
      CER_NOTE_NONE   = 3'h0,
      CER_NOTE_HALT   = 3'h1,
      CER_NOTE_MCHK   = 3'h3,
      CER_NOTE_KSNV   = 3'h2,
      CER_NOTE_HARD   = 3'h6,
      CER_NOTE_SOFT   = 3'h7
   } cer_note_t;
endpackage

// [hdl/cer_parity_inject.sv]
`timescale 1ns/1ps
// parity generator with deliberate bad-parity injection
module cer_parity_inject (
   input  wire logic [cer_pkg::DATA_W-1:0] wr_data,
   input  wire logic                       force_bad,
   output logic                            parity
);
   // inverting lets software exercise the detector later
   assign parity = (^wr_data) ^ force_bad; // RL16
endmodule

// [hdl/cer_priority.sv]
`timescale 1ns/1ps
// severity arbiter for error notifications
module cer_priority (
   input  wire logic               halt_req,
   input  wire logic               mchk_req,
   input  wire logic               ksnv_req,
   input  wire logic               hard_ok,
   input  wire logic               soft_ok,
   output cer_pkg::cer_note_t      note,
   output logic [7:0]              vector,
   output logic                    use_table
);
   // highest severity wins
   always_comb begin
      note      = cer_pkg::CER_NOTE_NONE;
      vector    = 8'h00;
      use_table = 1'b1;
      if (halt_req) begin
         note      = cer_pkg::CER_NOTE_HALT; // RL5
         use_table = 1'b0;                   // RL7
      end else if (mchk_req) begin
         note   = cer_pkg::CER_NOTE_MCHK;
         vector = cer_pkg::VEC_MACHINE_CHECK; // RL6
      end else if (ksnv_req) begin
         note   = cer_pkg::CER_NOTE_KSNV;
         vector = cer_pkg::VEC_KSNV;
      end else if (hard_ok) begin
         note   = cer_pkg::CER_NOTE_HARD;
         vector = cer_pkg::VEC_HARD_ERROR; // RL18
      end else if (soft_ok) begin
         note   = cer_pkg::CER_NOTE_SOFT;
         vector = cer_pkg::VEC_SOFT_ERROR; // RL17
      end
   end
endmodule

// [hdl/cer_top.sv]
`timescale 1ns/1ps
// cpu error reporting: notifications, force hit, syndrome, status latches
// Overview of operation
// RL1: force hit returns data on index match
// RL2: fill ecc still checked during force hit
// RL3: syndrome captured every read if errors disabled
// RL4: force hit set by control write
// RL5: halt, mchk, ksnv, hard, soft severity
// RL6: synchronous errors machine check vector 04
// RL7: console halt bypasses vector table
// RL8: ksnv on fault during stack push
// RL9: error interrupts only at instruction boundaries
// RL10: pending interrupts before retry if ipl low
// RL11: machine check aborts, return re-executes
// RL12: hard interrupt withdrawn when status cleared
// RL13: software disables caches in fixed order
// RL14: software re-enables caches in fixed order
// RL15: software flushes instruction cache banks differently
// RL16: bad parity writable into cache arrays
// RL17: soft errors use vector 54
// RL18: hard errors use vector 60
// RL19: status error bits write one to clear
// RL20: second error sets flag, keeps latches
// RL21: status bits sticky until software clears
module cer_top (
   input  wire logic                        sys_clk,
   input  wire logic                        reset_n,
   // backup_cache_control write
   input  wire logic                        bcc_wr,
   input  wire logic [1:0]                  bcc_wdata,
   output logic [1:0]                       backup_cache_control,
   // diagnostic_control write
   input  wire logic                        diag_wr,
   input  wire logic                        diag_wdata,
   // status write-one-to-clear
   input  wire logic                        stat_wr,
   input  wire logic [3:0]                  stat_wdata,
   output logic [3:0]                       bus_interface_error_status,
   output logic [cer_pkg::ADDR_W-1:0]       error_address,
   output logic [cer_pkg::SYND_W-1:0]       fill_syndrome,
   // memory-space read and backup cache line
   input  wire logic                        rd_valid,
   input  wire logic [cer_pkg::ADDR_W-1:0]  rd_addr,
   input  wire logic [cer_pkg::INDEX_W-1:0] line_index,
   input  wire logic [cer_pkg::DATA_W-1:0]  line_data,
   input  wire logic [cer_pkg::DATA_W-1:0]  mem_data,
   input  wire logic [cer_pkg::SYND_W-1:0]  rd_syndrome,
   input  wire logic                        rd_ecc_err,
   input  wire logic                        rd_uncorrectable,
   output logic                             rd_done,
   output logic [cer_pkg::DATA_W-1:0]       rd_data,
   output logic                             rd_hit,
   // asynchronous error sources
   input  wire logic                        soft_err_evt,
   input  wire logic                        hard_err_evt,
   input  wire logic [cer_pkg::ADDR_W-1:0]  err_evt_addr,
   // synchronous error sources and exception state
   input  wire logic                        sync_err_evt,
   input  wire logic                        mm_fault,
   input  wire logic                        pushing_stack,
   input  wire logic                        halt_evt,
   input  wire logic                        insn_boundary,
   input  wire logic                        return_from_exception,
   input  wire logic [cer_pkg::IPL_W-1:0]   interrupt_priority_level,
   // parity injection for cache writes
   input  wire logic [cer_pkg::DATA_W-1:0]  cache_wr_data,
   input  wire logic                        bad_parity_pc,
   input  wire logic                        bad_parity_ic,
   output logic                             pc_parity,
   output logic                             ic_parity,
   // notification outputs
   output logic                             note_valid,
   output logic [2:0]                       note_kind,
   output logic [7:0]                       note_vector,
   output logic [cer_pkg::ADDR_W-1:0]       note_target,
   output logic                             abort_insn,
   output logic                             retry_pending
);
   logic [1:0]                      next_bcc;
   logic                            diag_dis;
   logic                            next_diag_dis;
   logic [3:0]                      next_stat;
   logic [cer_pkg::ADDR_W-1:0]      next_addr;
   logic [cer_pkg::SYND_W-1:0]      next_synd;
   logic                            next_rd_done;
   logic [cer_pkg::DATA_W-1:0]      next_rd_data;
   logic                            next_rd_hit;
   logic                            mchk_pend;
   logic                            next_mchk_pend;
   logic                            in_mchk;
   logic                            next_in_mchk;
   logic                            next_note_valid;
   logic [2:0]                      next_note_kind;
   logic [7:0]                      next_note_vector;
   logic [cer_pkg::ADDR_W-1:0]      next_note_target;
   logic                            next_abort;
   logic                            next_retry;
   logic                            force_hit;
   logic                            idx_match;
   logic                            fill_err;
   logic                            any_latched;
   logic                            hard_ok;
   logic                            soft_ok;
   logic                            ksnv_req;
   cer_pkg::cer_note_t              arb_note;
   logic [7:0]                      arb_vec;
   logic                            arb_table;

   assign force_hit   = backup_cache_control[cer_pkg::BCC_FORCE_HIT_BIT];
   assign idx_match   = rd_addr[cer_pkg::INDEX_W-1:0] == line_index;
   assign fill_err    = rd_valid && rd_ecc_err;
   assign any_latched = bus_interface_error_status[cer_pkg::ST_HARD_BIT] |
                        bus_interface_error_status[cer_pkg::ST_SOFT_BIT] |
                        bus_interface_error_status[cer_pkg::ST_FILL_ECC_BIT];
   assign ksnv_req    = mm_fault && pushing_stack; // RL8

   // error interrupts only at boundaries, gated by current level
   assign hard_ok = insn_boundary && bus_interface_error_status[cer_pkg::ST_HARD_BIT]
                    && (interrupt_priority_level < cer_pkg::IPL_HARD); // RL9 RL12
   assign soft_ok = insn_boundary && bus_interface_error_status[cer_pkg::ST_SOFT_BIT]
                    && (interrupt_priority_level < cer_pkg::IPL_SOFT); // RL9

   cer_priority u_prio (
      .halt_req  (halt_evt),
      .mchk_req  (mchk_pend),
      .ksnv_req  (ksnv_req),
      .hard_ok   (hard_ok),
      .soft_ok   (soft_ok),
      .note      (arb_note),
      .vector    (arb_vec),
      .use_table (arb_table)
   );

   cer_parity_inject u_pc_par (
      .wr_data   (cache_wr_data),
      .force_bad (bad_parity_pc),
      .parity    (pc_parity)
   );

   cer_parity_inject u_ic_par (
      .wr_data   (cache_wr_data),
      .force_bad (bad_parity_ic),
      .parity    (ic_parity)
   );

   // control registers
   always_comb begin
      next_bcc      = backup_cache_control;
      next_diag_dis = diag_dis;
      if (bcc_wr) begin
         next_bcc = bcc_wdata; // RL4
      end
      if (diag_wr) begin
         next_diag_dis = diag_wdata;
      end
   end

   // read path: force hit or memory data
   always_comb begin
      next_rd_done = rd_valid;
      next_rd_hit  = 1'b0;
      next_rd_data = rd_data;
      next_synd    = fill_syndrome;
      if (rd_valid) begin
         if (force_hit && idx_match && !rd_uncorrectable) begin
            next_rd_data = line_data; // RL1
            next_rd_hit  = 1'b1;
         end else begin
            next_rd_data = mem_data;
         end
         // errors-disabled mode captures on every read; else only on an error while no hard, soft or fill ecc bit is latched
         if (diag_dis || (rd_ecc_err && !any_latched)) begin
            next_synd = rd_syndrome; // RL3
         end
      end
   end

   // status latches: a clear wins over a simultaneous error on a latched hard, soft or fill ecc bit; set wins on the second-error bit
   always_comb begin
      logic new_err;
      new_err   = 1'b0;
      next_stat = bus_interface_error_status;
      next_addr = error_address;
      if (stat_wr) begin
         next_stat = bus_interface_error_status & ~stat_wdata; // RL19
      end
      new_err = fill_err || soft_err_evt || hard_err_evt;
      if (new_err && any_latched) begin
         next_stat[cer_pkg::ST_SEO_BIT] = 1'b1; // RL20
      end else if (new_err) begin
         next_addr = fill_err ? rd_addr : err_evt_addr;
      end
      // first error only: a later one must not disturb the latched record
      if (!any_latched) begin
         // fill ecc checked regardless of force hit
         if (fill_err) begin
            next_stat[cer_pkg::ST_FILL_ECC_BIT] = 1'b1; // RL2 RL21
         end
         if (soft_err_evt || (fill_err && !rd_uncorrectable)) begin
            next_stat[cer_pkg::ST_SOFT_BIT] = 1'b1; // RL21
         end
         if (hard_err_evt) begin
            next_stat[cer_pkg::ST_HARD_BIT] = 1'b1; // RL21
         end
      end
   end

   // machine check pending and handler tracking
   always_comb begin
      next_mchk_pend = mchk_pend;
      next_in_mchk   = in_mchk;
      if (sync_err_evt || (fill_err && rd_uncorrectable)) begin
         next_mchk_pend = 1'b1; // RL6
      end else if (arb_note == cer_pkg::CER_NOTE_MCHK) begin
         next_mchk_pend = 1'b0;
         next_in_mchk   = 1'b1;
      end
      if (return_from_exception) begin
         next_in_mchk = 1'b0;
      end
   end

   // notification outputs, registered
   always_comb begin
      next_note_valid  = arb_note != cer_pkg::CER_NOTE_NONE;
      next_note_kind   = arb_note;
      next_note_vector = arb_vec;
      next_note_target = arb_table ? 32'h0000_0000 : cer_pkg::CONSOLE_HALT_ADDR; // RL7
      next_abort       = arb_note == cer_pkg::CER_NOTE_MCHK; // RL11
      // on return from handler, pending interrupt taken before re-execution
      next_retry       = return_from_exception && in_mchk && (hard_ok || soft_ok); // RL10
   end

   // registers
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         backup_cache_control       <= cer_pkg::BCC_RESET;
         diag_dis                   <= 1'b0;
         bus_interface_error_status <= cer_pkg::ST_RESET;
         error_address              <= 32'h0000_0000;
         fill_syndrome              <= 8'h00;
         rd_done                    <= 1'b0;
         rd_data                    <= 64'h0000_0000_0000_0000;
         rd_hit                     <= 1'b0;
         mchk_pend                  <= 1'b0;
         in_mchk                    <= 1'b0;
         note_valid                 <= 1'b0;
         note_kind                  <= 3'h0;
         note_vector                <= 8'h00;
         note_target                <= 32'h0000_0000;
         abort_insn                 <= 1'b0;
         retry_pending              <= 1'b0;
      end else begin
         backup_cache_control       <= next_bcc;
         diag_dis                   <= next_diag_dis;
         bus_interface_error_status <= next_stat;
         error_address              <= next_addr;
         fill_syndrome              <= next_synd;
         rd_done                    <= next_rd_done;
         rd_data                    <= next_rd_data;
         rd_hit                     <= next_rd_hit;
         mchk_pend                  <= next_mchk_pend;
         in_mchk                    <= next_in_mchk;
         note_valid                 <= next_note_valid;
         note_kind                  <= next_note_kind;
         note_vector                <= next_note_vector;
         note_target                <= next_note_target;
         abort_insn                 <= next_abort;
         retry_pending              <= next_retry;
      end
   end
endmodule
